// [itfa_top.sv]
`timescale 1ns/10ps


module itfa_top (
    // clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CE,
    // field terminals
    input wire logic [11:0] IN_WORD0,
    input wire logic [11:0] IN_WORD1,
    // avalon-mm slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // normal input words
    output logic [11:0] NORMAL_WORD0,
    output logic [11:0] NORMAL_WORD1,
    // high-speed counter phases
    output logic [3:0] HSC_PHASE_A,
    output logic [3:0] HSC_PHASE_B,
    output logic [3:0] HSC_PHASE_Z,
    // origin search inputs
    output logic [3:0] ORG_ORIGIN,
    output logic [3:0] ORG_PROXIMITY,
    // quick-response latches
    output logic [7:0] QUICK_LATCH,
    // interrupt
    output logic IRQ
);

    // ************************************************
    // decode helpers
    // ************************************************

    function automatic itfa_pkg::itfa_reg_t reg_of(input logic [7:0] a);
        itfa_pkg::itfa_reg_t r;
        r = itfa_pkg::RI_NONE;
        if (a == itfa_pkg::REG_INPUT_SEL) begin
            r = itfa_pkg::RI_SEL;
        end else if (a == itfa_pkg::REG_HSC_EN) begin
            r = itfa_pkg::RI_HSC;
        end else if (a == itfa_pkg::REG_ORG_EN) begin
            r = itfa_pkg::RI_ORG;
        end else if (a == itfa_pkg::REG_IMASK_CMD) begin
            r = itfa_pkg::RI_IMASK;
        end else if (a == itfa_pkg::REG_CNT_PRESET) begin
            r = itfa_pkg::RI_PRESET;
        end else if (a == itfa_pkg::REG_STATUS) begin
            r = itfa_pkg::RI_STATUS;
        end else if (a == itfa_pkg::REG_MASK) begin
            r = itfa_pkg::RI_MASK;
        end else if (a == itfa_pkg::REG_PIN_STATE) begin
            r = itfa_pkg::RI_PINS;
        end else if (a == itfa_pkg::REG_QUICK) begin
            r = itfa_pkg::RI_QUICK;
        end
        return r;
    endfunction

    // terminal index of interrupt / quick-response channel i
    function automatic logic [4:0] spec_idx(input int i);
        logic [4:0] t;
        t = 5'(i);
        if (i >= itfa_pkg::SPEC_LO_N) begin
            t = itfa_pkg::WORD1_BASE + 5'(i - itfa_pkg::SPEC_LO_N);
        end
        return t;
    endfunction

    // a zero preset is loaded as one, so it fires on every rising edge
    function automatic logic [itfa_pkg::CNT_W-1:0] load_of(
        input logic [itfa_pkg::CNT_W-1:0] p
    );
        logic [itfa_pkg::CNT_W-1:0] v;
        v = p;
        if (p == '0) begin
            v = itfa_pkg::CNT_W'(1);
        end
        return v;
    endfunction

    // ************************************************
    // pin synchroniser
    // ************************************************

    logic [itfa_pkg::TERM_N-1:0] pin_lvl;
    logic [itfa_pkg::TERM_N-1:0] pin_rise;

    itfa_sync #(
        .W(itfa_pkg::TERM_N)
    ) u_sync (
        .clk(SYS_CLK),
        .rst(RESET),
        .ce(CE),
        .din({IN_WORD1, IN_WORD0}),
        .level(pin_lvl),
        .rise(pin_rise)
    );

    // ************************************************
    // state
    // ************************************************

    itfa_pkg::itfa_state_t st_q;
    itfa_pkg::itfa_state_t st_d;
    itfa_pkg::itfa_fn_t fn [itfa_pkg::TERM_N];
    itfa_pkg::itfa_reg_t ri;
    logic req;
    logic done;
    logic [itfa_pkg::SPEC_N-1:0] ev;
    logic [itfa_pkg::SPEC_N-1:0] qset;
    logic [itfa_pkg::TERM_N-1:0] normal_v;
    logic [31:0] rd;

    // ************************************************
    // function allocation
    // ************************************************

    always_comb begin
        logic [4:0] t;
        t = '0;
        for (int k = 0; k < itfa_pkg::TERM_N; k++) begin
            fn[k] = itfa_pkg::FN_NORMAL;
        end
        // lowest priority: per-terminal input setting
        for (int i = 0; i < itfa_pkg::SPEC_N; i++) begin
            t = spec_idx(i);
            if (st_q.sel[2*i +: 2] == itfa_pkg::SEL_INTR) begin
                fn[t] = itfa_pkg::FN_INTR;
            end else if (st_q.sel[2*i +: 2] == itfa_pkg::SEL_QUICK) begin
                fn[t] = itfa_pkg::FN_QUICK;
            end
        end
        // counters override the input setting
        for (int c = 0; c < itfa_pkg::CH_N; c++) begin
            if (st_q.hsc_en[c]) begin
                fn[itfa_pkg::HSC_A_IDX[c]] = itfa_pkg::FN_HSC;
                fn[itfa_pkg::HSC_A_IDX[c] + 5'h01] = itfa_pkg::FN_HSC;
                fn[itfa_pkg::HSC_Z_IDX[c]] = itfa_pkg::FN_HSC;
            end
        end
        // origin search wins over everything
        for (int p = 0; p < itfa_pkg::CH_N; p++) begin
            if (st_q.org_en[p]) begin
                fn[itfa_pkg::ORG_IDX[p]] = itfa_pkg::FN_ORG;
                fn[itfa_pkg::ORG_IDX[p] + 5'h01] = itfa_pkg::FN_ORG;
            end
        end
    end

    // ************************************************
    // events and levels
    // ************************************************

    always_comb begin
        logic [4:0] t;
        t = '0;
        ev = '0;
        qset = '0;
        for (int k = 0; k < itfa_pkg::TERM_N; k++) begin
            // terminal taken by a special function reads zero here
            normal_v[k] = pin_lvl[k] & (fn[k] == itfa_pkg::FN_NORMAL);
        end
        for (int i = 0; i < itfa_pkg::SPEC_N; i++) begin
            t = spec_idx(i);
            if (pin_rise[t] && fn[t] == itfa_pkg::FN_INTR) begin
                if (!st_q.cmode[i]) begin
                    ev[i] = 1'b1;
                end else if (st_q.cnt[i] <= itfa_pkg::CNT_W'(1)) begin
                    ev[i] = 1'b1;
                end
            end
            if (pin_rise[t] && fn[t] == itfa_pkg::FN_QUICK) begin
                qset[i] = 1'b1;
            end
        end
    end

    // ************************************************
    // register read mux
    // ************************************************

    assign req = AVS_READ | AVS_WRITE;
    assign done = req & ~st_q.wait_q;
    assign ri = reg_of(AVS_ADDRESS);

    always_comb begin
        rd = '0;
        case (ri)
            itfa_pkg::RI_SEL: begin
                rd[15:0] = st_q.sel;
            end
            itfa_pkg::RI_HSC: begin
                rd[3:0] = st_q.hsc_en;
            end
            itfa_pkg::RI_ORG: begin
                rd[3:0] = st_q.org_en;
            end
            itfa_pkg::RI_IMASK: begin
                rd[7:0] = st_q.cmode;
            end
            itfa_pkg::RI_PRESET: begin
                rd[15:0] = st_q.preset;
            end
            itfa_pkg::RI_STATUS: begin
                rd[7:0] = st_q.status;
            end
            itfa_pkg::RI_MASK: begin
                rd[7:0] = st_q.mask;
            end
            itfa_pkg::RI_PINS: begin
                rd[23:0] = pin_lvl;
            end
            itfa_pkg::RI_QUICK: begin
                rd[7:0] = st_q.quick;
            end
            default: begin
                rd = '0;
            end
        endcase
    end

    // ************************************************
    // next state
    // ************************************************

    always_comb begin
        logic [4:0] t;
        logic reload;
        t = '0;
        reload = 1'b0;
        st_d = st_q;
        if (CE) begin
            // one wait cycle: data captured now, handed over next edge
            if (req && st_q.wait_q) begin
                st_d.wait_q = 1'b0;
                st_d.rdata = AVS_READ ? rd : '0;
            end else begin
                st_d.wait_q = 1'b1;
            end
            if (done && AVS_WRITE) begin
                case (ri)
                    itfa_pkg::RI_SEL: begin
                        st_d.sel = AVS_WRITEDATA[15:0];
                    end
                    itfa_pkg::RI_HSC: begin
                        st_d.hsc_en = AVS_WRITEDATA[3:0];
                    end
                    itfa_pkg::RI_ORG: begin
                        st_d.org_en = AVS_WRITEDATA[3:0];
                    end
                    itfa_pkg::RI_IMASK: begin
                        st_d.cmode = AVS_WRITEDATA[7:0];
                        reload = 1'b1;
                    end
                    itfa_pkg::RI_PRESET: begin
                        st_d.preset = AVS_WRITEDATA[15:0];
                        reload = 1'b1;
                    end
                    itfa_pkg::RI_MASK: begin
                        st_d.mask = AVS_WRITEDATA[7:0];
                    end
                    default: begin
                        reload = 1'b0;
                    end
                endcase
            end
            // read clears only what was seen, so a new event survives
            if (done && AVS_READ && ri == itfa_pkg::RI_STATUS) begin
                st_d.status = st_q.status & ~st_q.rdata[7:0];
            end
            if (done && AVS_READ && ri == itfa_pkg::RI_QUICK) begin
                st_d.quick = st_q.quick & ~st_q.rdata[7:0];
            end
            st_d.status = st_d.status | ev;
            st_d.quick = st_d.quick | qset;
            // counter-mode interrupts count down rising edges
            for (int i = 0; i < itfa_pkg::SPEC_N; i++) begin
                t = spec_idx(i);
                if (reload) begin
                    st_d.cnt[i] = load_of(st_d.preset);
                end else if (pin_rise[t] && fn[t] == itfa_pkg::FN_INTR
                             && st_q.cmode[i]) begin
                    if (ev[i]) begin
                        st_d.cnt[i] = load_of(st_q.preset);
                    end else begin
                        st_d.cnt[i] = st_q.cnt[i] - itfa_pkg::CNT_W'(1);
                    end
                end
            end
            st_d.irq = |(st_d.status & st_d.mask);
            // outputs registered from the resolved allocation
            st_d.nw0 = normal_v[itfa_pkg::WORD_W-1:0];
            st_d.nw1 = normal_v[itfa_pkg::TERM_N-1:itfa_pkg::WORD_W];
            for (int c = 0; c < itfa_pkg::CH_N; c++) begin
                st_d.ha[c] = st_q.hsc_en[c]
                    & pin_lvl[itfa_pkg::HSC_A_IDX[c]];
                st_d.hb[c] = st_q.hsc_en[c]
                    & pin_lvl[itfa_pkg::HSC_A_IDX[c] + 5'h01];
                // origin search may steal the Z terminal
                st_d.hz[c] = (fn[itfa_pkg::HSC_Z_IDX[c]] == itfa_pkg::FN_HSC)
                    & pin_lvl[itfa_pkg::HSC_Z_IDX[c]];
                st_d.oo[c] = st_q.org_en[c]
                    & pin_lvl[itfa_pkg::ORG_IDX[c]];
                st_d.op[c] = st_q.org_en[c]
                    & pin_lvl[itfa_pkg::ORG_IDX[c] + 5'h01];
            end
        end
    end

    // ************************************************
    // registers
    // ************************************************

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            st_q <= '0;
            st_q.sel <= itfa_pkg::SEL_RST;
            st_q.preset <= itfa_pkg::PRESET_RST;
            st_q.cnt <= {itfa_pkg::SPEC_N{itfa_pkg::PRESET_RST}};
            st_q.wait_q <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************
    // outputs
    // ************************************************

    assign AVS_READDATA = st_q.rdata;
    assign AVS_WAITREQUEST = st_q.wait_q;
    assign NORMAL_WORD0 = st_q.nw0;
    assign NORMAL_WORD1 = st_q.nw1;
    assign HSC_PHASE_A = st_q.ha;
    assign HSC_PHASE_B = st_q.hb;
    assign HSC_PHASE_Z = st_q.hz;
    assign ORG_ORIGIN = st_q.oo;
    assign ORG_PROXIMITY = st_q.op;
    assign QUICK_LATCH = st_q.quick;
    assign IRQ = st_q.irq;

endmodule // itfa_top

// [itfa_pkg.sv]
package itfa_pkg;

    // ************************************************
    // terminal layout
    // ************************************************
    localparam int WORD_W = 12;
    localparam int TERM_N = 24;
    localparam int SPEC_N = 8;
    localparam int CH_N = 4;
    localparam int SPEC_LO_N = 4;
    localparam logic [4:0] WORD1_BASE = 5'h0c;
    localparam int CNT_W = 16;

    // counter phase A terminal per counter 3..0, phase B is the next bit
    localparam logic [3:0][4:0] HSC_A_IDX = {5'h0a, 5'h04, 5'h06, 5'h08};
    localparam logic [3:0][4:0] HSC_Z_IDX = {5'h0c, 5'h01, 5'h02, 5'h03};
    // origin terminal per pulse output 3..0, proximity is the next bit
    localparam logic [3:0][4:0] ORG_IDX = {5'h0e, 5'h0c, 5'h02, 5'h00};

    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam logic [7:0] REG_INPUT_SEL = 8'h00;
    localparam logic [7:0] REG_HSC_EN = 8'h04;
    localparam logic [7:0] REG_ORG_EN = 8'h08;
    localparam logic [7:0] REG_IMASK_CMD = 8'h0c;
    localparam logic [7:0] REG_CNT_PRESET = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam logic [7:0] REG_PIN_STATE = 8'h1c;
    localparam logic [7:0] REG_QUICK = 8'h20;

    localparam logic [15:0] SEL_RST = 16'h0000;
    localparam logic [CNT_W-1:0] PRESET_RST = 16'h0001;

    // per-terminal input setting, two bits each
    localparam logic [1:0] SEL_NORMAL = 2'h0;
    localparam logic [1:0] SEL_INTR = 2'h1;
    localparam logic [1:0] SEL_QUICK = 2'h2;

    typedef enum logic [2:0] {
        FN_NORMAL = 3'h0,
        FN_INTR = 3'h1,
        FN_QUICK = 3'h3,
        FN_HSC = 3'h2,
        FN_ORG = 3'h6
    } itfa_fn_t;

    typedef enum logic [3:0] {
        RI_NONE, RI_SEL, RI_HSC, RI_ORG, RI_IMASK,
        RI_PRESET, RI_STATUS, RI_MASK, RI_PINS, RI_QUICK
    } itfa_reg_t;

    typedef struct packed {
        logic [15:0] sel;
        logic [CH_N-1:0] hsc_en;
        logic [CH_N-1:0] org_en;
        logic [SPEC_N-1:0] cmode;
        logic [CNT_W-1:0] preset;
        logic [SPEC_N-1:0][CNT_W-1:0] cnt;
        logic [SPEC_N-1:0] status;
        logic [SPEC_N-1:0] mask;
        logic [SPEC_N-1:0] quick;
        logic wait_q;
        logic [31:0] rdata;
        logic irq;
        logic [WORD_W-1:0] nw0;
        logic [WORD_W-1:0] nw1;
        logic [CH_N-1:0] ha;
        logic [CH_N-1:0] hb;
        logic [CH_N-1:0] hz;
        logic [CH_N-1:0] oo;
        logic [CH_N-1:0] op;
    } itfa_state_t;

    typedef struct packed {
        logic [TERM_N-1:0] s1;
        logic [TERM_N-1:0] s2;
        logic [TERM_N-1:0] prev;
    } itfa_sync_t;

endpackage

// [itfa_sync.sv]
`timescale 1ns/10ps

module itfa_sync #(
    parameter int W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // pins in
    input wire logic [W-1:0] din,
    // synchronised level and rising edge
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] prev;
    } itfa_sync_st_t;

    itfa_sync_st_t st_q;
    itfa_sync_st_t st_d;

    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.s1 = din;
            st_d.s2 = st_q.s1;
            st_d.prev = st_q.s2;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise = st_q.s2 & ~st_q.prev;

endmodule // itfa_sync

// [itfa_chk.sv]
`timescale 1ns/10ps

module itfa_chk (
    // clock, reset, enable
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CE,
    // terminals
    input wire logic [11:0] IN_WORD0,
    input wire logic [11:0] IN_WORD1,
    // bus
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // routed functions
    input wire logic [11:0] NORMAL_WORD0,
    input wire logic [11:0] NORMAL_WORD1,
    input wire logic [3:0] HSC_PHASE_A,
    input wire logic [3:0] HSC_PHASE_B,
    input wire logic [3:0] HSC_PHASE_Z,
    input wire logic [3:0] ORG_ORIGIN,
    input wire logic [3:0] ORG_PROXIMITY,
    input wire logic [7:0] QUICK_LATCH,
    input wire logic IRQ
);
    // ************************************************
    // properties
    // ************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    sequence s_req;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_ans;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    property p_bus;
        s_req |=> s_ans;
    endproperty
    // an output bit may only be high if its own terminal was high three edges back
    property p_norm0;
        (NORMAL_WORD0 & ~$past(IN_WORD0, 3)) == 12'h000;
    endproperty
    property p_word1;
        !$past(RESET, 1) && !$past(RESET, 2) && !$past(RESET, 3)
            |-> NORMAL_WORD1[11:4] == $past(IN_WORD1[11:4], 3);
    endproperty
    property p_hsc_ab;
        ((HSC_PHASE_A & ~$past({IN_WORD0[10], IN_WORD0[4], IN_WORD0[6], IN_WORD0[8]}, 3))
            | (HSC_PHASE_B & ~$past({IN_WORD0[11], IN_WORD0[5], IN_WORD0[7], IN_WORD0[9]}, 3)))
            == 4'h0;
    endproperty
    property p_hsc_z;
        (HSC_PHASE_Z & ~$past({IN_WORD1[0], IN_WORD0[1], IN_WORD0[2], IN_WORD0[3]}, 3)) == 4'h0;
    endproperty
    property p_org;
        ((ORG_ORIGIN & ~$past({IN_WORD1[2], IN_WORD1[0], IN_WORD0[2], IN_WORD0[0]}, 3))
            | (ORG_PROXIMITY & ~$past({IN_WORD1[3], IN_WORD1[1], IN_WORD0[3], IN_WORD0[1]}, 3)))
            == 4'h0;
    endproperty
    property p_prio;
        (HSC_PHASE_Z & {ORG_ORIGIN[2], ORG_PROXIMITY[0], ORG_ORIGIN[1], ORG_PROXIMITY[1]}) == 4'h0;
    endproperty
    property p_excl;
        (NORMAL_WORD0[11:4] & {HSC_PHASE_B[3], HSC_PHASE_A[3], HSC_PHASE_B[0], HSC_PHASE_A[0],
            HSC_PHASE_B[1], HSC_PHASE_A[1], HSC_PHASE_B[2], HSC_PHASE_A[2]}) == 8'h00;
    endproperty
    property p_quick;
        ($rose(QUICK_LATCH[0]) |-> $past(IN_WORD0[0], 3) && !$past(IN_WORD0[0], 4))
            and ($rose(QUICK_LATCH[4]) |-> $past(IN_WORD1[0], 3) && !$past(IN_WORD1[0], 4));
    endproperty

    a_bus: assert property (p_bus) else $error("waitrequest answer wrong");
    a_norm0: assert property (p_norm0) else $error("normal word0 bit without pin");
    a_word1: assert property (p_word1) else $error("word1 upper bits not plain");
    a_hsc_ab: assert property (p_hsc_ab) else $error("counter phase a/b routing");
    a_hsc_z: assert property (p_hsc_z) else $error("counter phase z routing");
    a_org: assert property (p_org) else $error("origin input routing");
    a_prio: assert property (p_prio) else $error("phase z beat origin search");
    a_excl: assert property (p_excl) else $error("normal bit shown beside counter");
    a_quick: assert property (p_quick) else $error("quick latch without edge");
endmodule // itfa_chk

bind itfa_top itfa_chk u_chk (.SYS_CLK, .RESET, .CE, .IN_WORD0, .IN_WORD1, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .NORMAL_WORD0,
    .NORMAL_WORD1, .HSC_PHASE_A, .HSC_PHASE_B, .HSC_PHASE_Z, .ORG_ORIGIN, .ORG_PROXIMITY,
    .QUICK_LATCH, .IRQ);

// [itfa_field.sv]
`timescale 1ns/10ps

module itfa_field (
    // clock
    input wire logic clk,
    // steady levels and pulse request
    input wire logic [23:0] lvl,
    input wire logic [23:0] pmask,
    input wire logic [3:0] np,
    input wire logic [3:0] wid,
    input wire logic go,
    // terminals
    output logic [11:0] w0,
    output logic [11:0] w1,
    output logic busy
);
    // ************************************************
    // sensor pulses
    // ************************************************
    logic [23:0] pul = 24'h000000;
    // one process owns the busy flag
    logic run = 1'b0;
    assign busy = run;
    assign {w1, w0} = lvl | pul;
    // wid sets slow or prompt sensors; one request at a time
    always @(posedge clk) begin
        if (go && !run) begin
            run <= 1'b1;
            for (int i = 0; i < np; i++) begin
                pul <= pmask;
                repeat (wid) @(posedge clk);
                pul <= 24'h000000;
                repeat (wid) @(posedge clk);
            end
            run <= 1'b0;
        end
    end
endmodule // itfa_field

// [test_itfa_top.sv]
`timescale 1ns/10ps

module test_itfa_top;
    // ************************************************
    // bench
    // ************************************************
    typedef struct packed {
        logic [1:0] k;
        logic [43:0] v;
    } itfa_note_t;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic wait_r, irq, busy;
    logic [11:0] in0, in1, nw0, nw1;
    logic [3:0] ha, hb, hz, oo, op;
    logic [7:0] ql;
    logic [43:0] rt;
    assign rt = {nw1, nw0, ha, hb, hz, oo, op};
    logic ce = 1'b1;
    logic [23:0] lvl = 24'h000000;
    logic [23:0] pmask = 24'h000000;
    logic [3:0] np = 4'h0;
    logic [3:0] wid = 4'h2;
    logic go = 1'b0;
    logic smp = 1'b0;
    itfa_note_t notes[$];
    itfa_note_t n;
    int err_total = 0;
    int num_checks = 0;
    int seed = 32'hb4d7;
    int cyc = 0;

    itfa_top dut_u (.SYS_CLK(sys_clk), .RESET(reset), .CE(ce), .IN_WORD0(in0),
        .IN_WORD1(in1), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
        .NORMAL_WORD0(nw0), .NORMAL_WORD1(nw1), .HSC_PHASE_A(ha), .HSC_PHASE_B(hb),
        .HSC_PHASE_Z(hz), .ORG_ORIGIN(oo), .ORG_PROXIMITY(op), .QUICK_LATCH(ql), .IRQ(irq));
    itfa_field field_u (.clk(sys_clk), .lvl(lvl), .pmask(pmask), .np(np), .wid(wid),
        .go(go), .w0(in0), .w1(in1), .busy(busy));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [43:0] seen, input logic [43:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // kind 0 read data, 1 routing, 2 quick latch and irq, 3 read whose value is not predicted
    always @(posedge sys_clk) begin
        cyc++;
        if ((rd && !wait_r) || smp) begin
            n = notes.pop_front();
            if (n.k == 2'h0) check("readdata", {12'h000, rdata}, n.v);
            else if (n.k == 2'h1) check("routing", rt, n.v);
            else if (n.k == 2'h2) check("irq", {35'h0, ql, irq}, n.v);
        end
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge sys_clk);
        while (wait_r !== 1'b0) @(posedge sys_clk);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] k = 2'h0);
        notes.push_back({k, 12'h000, e});
        bus(1'b0, a, 32'h0);
    endtask

    task automatic expect_k(input logic [1:0] k, input logic [43:0] v);
        notes.push_back({k, v});
        smp <= 1'b1;
        @(posedge sys_clk);
        smp <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic pulse(input logic [23:0] m, input logic [3:0] cnt);
        pmask <= m;
        np <= cnt;
        go <= 1'b1;
        repeat (2) @(posedge sys_clk);
        go <= 1'b0;
        while (busy !== 1'b0) @(posedge sys_clk);
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic chk_rst();
        bus(1'b1, 8'h24, 32'hffffffff);
        rdx(8'h24, 32'h0);
        rdx(8'h00, 32'h0);
        rdx(8'h04, 32'h0);
        rdx(8'h08, 32'h0);
        rdx(8'h0c, 32'h0);
        rdx(8'h10, 32'h1);
        rdx(8'h14, 32'h0);
        rdx(8'h18, 32'h0);
        rdx(8'h20, 32'h0);
    endtask

    function automatic logic [43:0] route(input logic [23:0] t, input logic [15:0] s,
        input logic [3:0] h, input logic [3:0] o);
        int ai[4] = '{8, 6, 4, 10};
        int zi[4] = '{3, 2, 1, 12};
        int oi[4] = '{0, 2, 12, 14};
        logic [23:0] tk;
        logic [3:0] a, b, z, g, p;
        tk = 24'h000000;
        for (int c = 0; c < 4; c++) begin
            g[c] = o[c] & t[oi[c]];
            p[c] = o[c] & t[oi[c] + 1];
            tk[oi[c]] |= o[c];
            tk[oi[c] + 1] |= o[c];
        end
        for (int c = 0; c < 4; c++) begin
            a[c] = h[c] & t[ai[c]];
            b[c] = h[c] & t[ai[c] + 1];
            z[c] = h[c] & !tk[zi[c]] & t[zi[c]];
            tk[ai[c]] |= h[c];
            tk[ai[c] + 1] |= h[c];
            tk[zi[c]] |= h[c];
        end
        for (int i = 0; i < 8; i++) begin
            if (s[2 * i +: 2] == 2'h1 || s[2 * i +: 2] == 2'h2) tk[i < 4 ? i : i + 8] = 1'b1;
        end
        return {t & ~tk, a, b, z, g, p};
    endfunction

    initial begin
        logic [31:0] d;
        logic [23:0] t;
        do_reset();
        chk_rst();
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            bus(1'b1, 8'h00, d);
            rdx(8'h00, {16'h0, d[15:0]});
            bus(1'b1, 8'h18, d);
            rdx(8'h18, {24'h0, d[7:0]});
            bus(1'b1, 8'h0c, d);
            rdx(8'h0c, {24'h0, d[7:0]});
            bus(1'b1, 8'h10, {d[31:1], 1'b1});
            rdx(8'h10, {16'h0, d[15:1], 1'b1});
        end
        bus(1'b1, 8'h18, 32'h0);
        // random mixes include shared terminals on purpose
        for (int i = 0; i < 40; i++) begin
            d = $random(seed);
            t = 24'($random(seed));
            bus(1'b1, 8'h00, {16'h0, d[15:0]});
            bus(1'b1, 8'h04, {28'h0, d[19:16]});
            bus(1'b1, 8'h08, {28'h0, d[23:20]});
            lvl <= t;
            repeat (5) @(posedge sys_clk);
            expect_k(2'h1, route(t, d[15:0], d[19:16], d[23:20]));
            rdx(8'h1c, {8'h0, t});
        end
        lvl <= 24'h000000;
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h0c, 32'h0);
        bus(1'b1, 8'h00, 32'h5555);
        rdx(8'h14, 32'h0, 2'h3);
        rdx(8'h20, 32'h0, 2'h3);
        bus(1'b1, 8'h18, 32'hff);
        wid <= 4'h5;
        pulse(24'h00f00f, 4'h1);
        expect_k(2'h2, 44'h1);
        rdx(8'h14, 32'hff);
        rdx(8'h14, 32'h0);
        expect_k(2'h2, 44'h0);
        // frozen block must not see a pulse that is gone before it wakes
        ce <= 1'b0;
        pulse(24'h00f00f, 4'h1);
        ce <= 1'b1;
        rdx(8'h14, 32'h0);
        bus(1'b1, 8'h18, 32'h0f);
        wid <= 4'h2;
        pulse(24'h001000, 4'h1);
        expect_k(2'h2, 44'h0);
        rdx(8'h14, 32'h10);
        bus(1'b1, 8'h10, 32'h3);
        bus(1'b1, 8'h0c, 32'h1);
        pulse(24'h000001, 4'h5);
        rdx(8'h14, 32'h1);
        rdx(8'h14, 32'h0);
        pulse(24'h000001, 4'h1);
        rdx(8'h14, 32'h1);
        bus(1'b1, 8'h0c, 32'h0);
        bus(1'b1, 8'h00, 32'haaaa);
        pulse(24'h00f00f, 4'h1);
        expect_k(2'h2, 44'h1fe);
        rdx(8'h20, 32'hff);
        rdx(8'h20, 32'h0);
        rdx(8'h14, 32'h0);
        bus(1'b1, 8'h00, 32'h5555);
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b1, 8'h08, 32'h2);
        pulse(24'h00f00f, 4'h1);
        rdx(8'h14, 32'hf1);
        do_reset();
        chk_rst();
        end_sim();
    end
endmodule // test_itfa_top
